//--- acg_gateway.sv
// ASCII command gateway: parses terminal commands, issues network
// register accesses and print messages, replies in decimal ASCII.
// Assumes rx bytes arrive already deframed and a transport answers requests.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Letter, decimal parameters, CR or pause ends
// - Packet ends on count or time limit
// - R register, optional count, free delimiters
// - First non-digit ends each number
// - Read reply: decimals, spaces, final CR
// - W register then values to successive registers
// - S register bit sets one bit
// - C register bit clears one bit
// - B replies ASCII 1 or 0
// - P forwards text, CR LF appended
// - O forwards text exactly, nothing appended
// - A stores up to eight route drops
// - Empty route targets local registers
// - Route also reachable through config registers
module acg_gateway
	import acg_pkg::*;
#(
	parameter int TICK_CYC = ACG_TICK_CYC,
	parameter int DEPTH    = ACG_FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             rx_valid,
	input  wire logic [7:0]       rx_data,
	output var  logic             rx_ready,
	output var  logic             tx_valid,
	output var  logic [7:0]       tx_data,
	input  wire logic             tx_ready,
	output var  logic             net_req_valid,
	output var  acg_pkg::acg_op_e net_req_op,
	output var  logic [15:0]      net_req_addr,
	output var  logic [15:0]      net_req_data,
	output var  logic [15:0]      net_req_mask,
	output var  logic             net_local,
	input  wire logic             net_req_ready,
	input  wire logic             net_rsp_valid,
	input  wire logic [15:0]      net_rsp_data,
	input  wire logic             net_rsp_err,
	output var  logic             prt_valid,
	output var  logic [7:0]       prt_data,
	output var  logic             prt_last,
	output var  logic             prt_empty,
	input  wire logic             prt_ready,
	input  wire logic [acg_pkg::ACG_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output var  logic [31:0]      reg_rdata
);
	import acg_pkg::*;
	localparam int DIVW = $clog2(TICK_CYC);
	localparam logic [DIVW-1:0] DIV_LAST = DIVW'(TICK_CYC - 1);
	localparam int NP = ACG_MAX_PARAMS;

	typedef struct packed {
		acg_state_e          st;
		logic [7:0]          cmd;
		logic [15:0]         acc;
		logic                in_num;
		logic [3:0]          np;
		logic [NP-1:0][15:0] par;
		logic [7:0]          nchar;
		logic [7:0]          tticks;
		logic [DIVW-1:0]     div;
		logic                tick;
		logic [15:0]         idx;
		logic [15:0]         cnt;
		logic [15:0]         val;
		logic [2:0]          pos;
		logic [3:0]          dig;
		logic                seen;
		logic                tx_valid;
		logic [7:0]          tx_data;
		logic                prt_valid;
		logic [7:0]          prt_data;
		logic                prt_last;
		logic                prt_empty;
		logic                req_valid;
		acg_op_e             req_op;
		logic [15:0]         req_addr;
		logic [15:0]         req_data;
		logic [15:0]         req_mask;
		logic                local_tgt;
		logic [31:0]         rdata;
		logic                en;
		logic [7:0]          size_lim;
		logic [7:0]          time_lim;
		logic [3:0]          route_len;
		logic [ACG_MAX_DROPS-1:0][7:0] route;
	} acg_regs_s;
	acg_regs_s r, n;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic is_digit(input logic [7:0] c);
		return (c >= 8'h30) && (c <= 8'h39);
	endfunction

	// Case folding so either case selects the same command
	function automatic logic [7:0] to_upper(input logic [7:0] c);
		return ((c >= 8'h61) && (c <= 8'h7A)) ? (c & 8'hDF) : c;
	endfunction

	// Bits are numbered 1 to 16; out-of-range gives an empty mask
	function automatic logic [15:0] bit_mask(input logic [15:0] b);
		return ((b >= 16'h0001) && (b <= 16'h0010)) ? (16'h0001 << (b - 16'h0001)) : 16'h0000;
	endfunction

	function automatic logic [15:0] pow10(input logic [2:0] p);
		unique case (p)
			3'h0: return 16'h2710;
			3'h1: return 16'h03E8;
			3'h2: return 16'h0064;
			3'h3: return 16'h000A;
			default: return 16'h0001;
		endcase
	endfunction

	// Route drop register decode: hit flag and drop index
	function automatic logic [3:0] drop_sel(input logic [7:0] a);
		logic [7:0] d;
		d = a - ACG_OFS_DROP0;
		return {(a >= ACG_OFS_DROP0) && (d[7:5] == 3'h0) && (d[1:0] == 2'h0), d[4:2]};
	endfunction

	// ------------------------------------------------------------
	// Receive FIFO
	// ------------------------------------------------------------
	logic       f_valid;
	logic [7:0] f_data;
	logic       f_pop;

	acg_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (rx_valid),
		.in_data   (rx_data),
		.in_ready  (rx_ready),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (f_pop)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic       tx_free, prt_free, got, pkt_end, cnt_hit, t_hit;
	logic [7:0] c;
	logic [3:0] ds;

	always_comb
	begin
		n = r;
		f_pop = 1'b0;
		tx_free  = !r.tx_valid || tx_ready;
		prt_free = !r.prt_valid || prt_ready;
		if (r.tx_valid && tx_ready)
			n.tx_valid = 1'b0;
		if (r.prt_valid && prt_ready)
			n.prt_valid = 1'b0;
		c = to_upper(f_data);
		ds = 4'h0;
		// Hundredth-second enable for the inter-character timer
		n.tick = (r.div == DIV_LAST);
		n.div  = n.tick ? '0 : DIVW'(r.div + 1'b1);
		// Packet end conditions shared by argument and print collection
		got = 1'b0;
		cnt_hit = (r.size_lim != 8'h00) &&
			(({1'b0, r.nchar} + 9'h001) >= {1'b0, r.size_lim});
		t_hit = r.tick && (r.time_lim != 8'h00) &&
			(8'(r.tticks + 8'h01) >= r.time_lim);
		pkt_end = 1'b0;
		unique case (r.st)
			ST_IDLE:
			begin
				f_pop = f_valid && r.en;
				// Only a letter opens a command; stray characters are dropped
				if (f_pop && (c >= ACG_CH_A) && (c <= 8'h5A))
				begin
					n.cmd = c;
					n.nchar = 8'h01;
					n.tticks = 8'h00;
					n.np = 4'h0;
					n.par = '0;                                   // No stale bit number reused
					n.in_num = 1'b0;
					n.acc = 16'h0000;
					n.st = ((c == ACG_CH_P) || (c == ACG_CH_O)) ? ST_PRINT : ST_ARGS;
				end
			end
			ST_ARGS:
			begin
				f_pop = f_valid;
				got = f_valid;
				if (got && is_digit(f_data))
				begin
					n.acc = 16'(r.acc * 16'h000A + {12'h000, f_data[3:0]});
					n.in_num = 1'b1;
				end
				else if (got && r.in_num)
				begin
					n.in_num = 1'b0;
					if (r.np < 4'(NP))
					begin
						n.par[r.np] = r.acc;
						n.np = 4'(r.np + 4'h1);
					end
					n.acc = 16'h0000;
				end
				pkt_end = (got && (f_data == ACG_CH_CR)) || (got && cnt_hit) ||
					(!got && t_hit);
				// A number running into the end of the packet still counts
				if (pkt_end && !got && r.in_num && (r.np < 4'(NP)))
				begin
					n.par[r.np] = r.acc;
					n.np = 4'(r.np + 4'h1);
				end
				else if (pkt_end && got && is_digit(f_data) && (r.np < 4'(NP)))
				begin
					n.par[r.np] = n.acc;
					n.np = 4'(r.np + 4'h1);
				end
				if (pkt_end)
					n.st = ST_EXEC;
			end
			ST_PRINT:
			begin
				// Forward every character, the closing CR included
				f_pop = f_valid && prt_free;
				got = f_pop;
				if (got)
				begin
					n.prt_valid = 1'b1;
					n.prt_data = f_data;
					n.prt_last = 1'b0;
					n.prt_empty = 1'b0;
				end
				pkt_end = (got && (f_data == ACG_CH_CR)) || (got && cnt_hit) ||
					(!f_valid && t_hit);
				if (pkt_end)
					n.st = (r.cmd == ACG_CH_P) ? ST_PCR : ST_PEND;
			end
			ST_PCR:
				if (prt_free)
				begin
					n.prt_valid = 1'b1;
					n.prt_data = ACG_CH_CR;
					n.prt_last = 1'b0;
					n.prt_empty = 1'b0;
					n.st = ST_PLF;
				end
			ST_PLF:
				if (prt_free)
				begin
					n.prt_valid = 1'b1;
					n.prt_data = ACG_CH_LF;
					n.st = ST_PEND;
				end
			ST_PEND:
				if (prt_free)
				begin
					n.prt_valid = 1'b1;
					n.prt_data = 8'h00;
					n.prt_last = 1'b1;
					n.prt_empty = 1'b1;
					n.st = ST_IDLE;
				end
			ST_EXEC:
			begin
				n.idx = 16'h0000;
				n.req_addr = r.par[0];
				n.req_data = 16'h0000;
				n.req_mask = 16'h0000;
				n.cnt = 16'h0001;
				n.st = ST_CR;
				unique case (r.cmd)
					ACG_CH_R, ACG_CH_B:
						if (r.np != 4'h0)
						begin
							if ((r.cmd == ACG_CH_R) && (r.np > 4'h1) && (r.par[1] != 16'h0000))
								n.cnt = r.par[1];
							n.req_op = OP_READ;
							n.req_mask = bit_mask(r.par[1]);
							n.req_valid = 1'b1;
							n.st = ST_REQ;
						end
					ACG_CH_W:
						if (r.np > 4'h1)
						begin
							n.cnt = {12'h000, 4'(r.np - 4'h1)};
							n.req_op = OP_WRITE;
							n.req_data = r.par[1];
							n.req_valid = 1'b1;
							n.st = ST_REQ;
						end
					ACG_CH_S, ACG_CH_C:
						if (r.np > 4'h1)
						begin
							n.req_op = (r.cmd == ACG_CH_S) ? OP_SETBIT : OP_CLRBIT;
							n.req_mask = bit_mask(r.par[1]);
							n.req_valid = 1'b1;
							n.st = ST_REQ;
						end
					ACG_CH_A:
					begin
						for (int i = 0; i < ACG_MAX_DROPS; i++)
							n.route[i] = (4'(i) < r.np) ? r.par[i][7:0] : 8'h00;
						n.route_len = (r.np > 4'(ACG_MAX_DROPS)) ? 4'(ACG_MAX_DROPS) : r.np;
					end
					default:
						n.st = ST_IDLE;                              // Unknown letter: silent
				endcase
			end
			ST_REQ:
				if (net_req_ready)
				begin
					n.req_valid = 1'b0;
					if (r.req_op == OP_READ)
						n.st = ST_RSP;
					else if (16'(r.idx + 16'h0001) < r.cnt)
					begin
						n.idx = 16'(r.idx + 16'h0001);
						n.req_addr = 16'(r.par[0] + n.idx);
						n.req_data = r.par[n.idx[3:0] + 4'h1];
						n.req_valid = 1'b1;
					end
					else
						n.st = ST_CR;
				end
			ST_RSP:
				if (net_rsp_valid)
				begin
					n.pos = 3'h0;
					n.dig = 4'h0;
					n.seen = 1'b0;
					if (net_rsp_err)
						n.st = ST_CR;
					else if (r.cmd == ACG_CH_B)
					begin
						n.val = {15'h0000, (net_rsp_data & r.req_mask) != 16'h0000};
						n.st = ST_DEC;
					end
					else
					begin
						n.val = net_rsp_data;
						n.st = (r.idx != 16'h0000) ? ST_SP : ST_DEC;
					end
				end
			ST_SP:
				if (tx_free)
				begin
					n.tx_valid = 1'b1;
					n.tx_data = ACG_CH_SP;
					n.st = ST_DEC;
				end
			ST_DEC:
				// One subtraction per cycle; leading zeros suppressed
				if (r.val >= pow10(r.pos))
				begin
					n.val = 16'(r.val - pow10(r.pos));
					n.dig = 4'(r.dig + 4'h1);
				end
				else if (!((r.dig != 4'h0) || r.seen || (r.pos == 3'h4)) || tx_free)
				begin
					if ((r.dig != 4'h0) || r.seen || (r.pos == 3'h4))
					begin
						n.tx_valid = 1'b1;
						n.tx_data = 8'(ACG_CH_0 + {4'h0, r.dig});
						n.seen = 1'b1;
					end
					n.dig = 4'h0;
					n.pos = 3'(r.pos + 3'h1);
					if (r.pos == 3'h4)
					begin
						n.st = ST_CR;
						if (16'(r.idx + 16'h0001) < r.cnt)
						begin
							n.idx = 16'(r.idx + 16'h0001);
							n.req_addr = 16'(r.par[0] + n.idx);
							n.req_valid = 1'b1;
							n.st = ST_REQ;
						end
					end
				end
			ST_CR:
				if (tx_free)
				begin
					n.tx_valid = 1'b1;
					n.tx_data = ACG_CH_CR;
					n.st = ST_IDLE;
				end
			default:
				n.st = ST_IDLE;
		endcase
		// Inter-character timer restarts on every character taken
		if (got)
		begin
			n.nchar = 8'(r.nchar + 8'h01);
			n.tticks = 8'h00;
		end
		else if (r.tick)
			n.tticks = 8'(r.tticks + 8'h01);
		// Register port: read data stands in the following cycle only
		n.rdata = 32'h0000_0000;
		if (reg_rd)
		begin
			ds = drop_sel(reg_addr);
			unique case (reg_addr)
				ACG_OFS_CTRL:      n.rdata = {31'h0, r.en};
				ACG_OFS_SIZE_LIM:  n.rdata = {24'h0, r.size_lim};
				ACG_OFS_TIME_LIM:  n.rdata = {24'h0, r.time_lim};
				ACG_OFS_ROUTE_LEN: n.rdata = {28'h0, r.route_len};
				ACG_OFS_STATUS:    n.rdata = {27'h0, r.st != ST_IDLE, r.st};
				default:
					if (ds[3])
						n.rdata = {24'h0, r.route[ds[2:0]]};
			endcase
		end
		else if (reg_wr)
		begin
			ds = drop_sel(reg_addr);
			unique case (reg_addr)
				ACG_OFS_CTRL:      n.en = reg_wdata[ACG_CTRL_EN_BIT];
				ACG_OFS_SIZE_LIM:  n.size_lim = reg_wdata[7:0];
				ACG_OFS_TIME_LIM:  n.time_lim = reg_wdata[7:0];
				ACG_OFS_ROUTE_LEN:
					n.route_len = (reg_wdata[3:0] > 4'(ACG_MAX_DROPS)) ?
						4'(ACG_MAX_DROPS) : reg_wdata[3:0];
				default:
					if (ds[3])
						n.route[ds[2:0]] = reg_wdata[7:0];
			endcase
		end
		n.local_tgt = (n.route_len == 4'h0);
	end

	// ------------------------------------------------------------
	// Registered state
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			r <= '0;
			r.st <= ST_IDLE;
			r.en <= ACG_RST_EN;
			r.size_lim <= ACG_RST_SIZE_LIM;
			r.time_lim <= ACG_RST_TIME_LIM;
			r.local_tgt <= 1'b1;
		end
		else
			r <= n;
	end

	assign tx_valid      = r.tx_valid;
	assign tx_data       = r.tx_data;
	assign net_req_valid = r.req_valid;
	assign net_req_op    = r.req_op;
	assign net_req_addr  = r.req_addr;
	assign net_req_data  = r.req_data;
	assign net_req_mask  = r.req_mask;
	assign net_local     = r.local_tgt;
	assign prt_valid     = r.prt_valid;
	assign prt_data      = r.prt_data;
	assign prt_last      = r.prt_last;
	assign prt_empty     = r.prt_empty;
	assign reg_rdata     = r.rdata;
endmodule // acg_gateway
`default_nettype wire

//--- acg_pkg.sv
// Constants shared by the ASCII command gateway and its receive FIFO.
// Assumes a single 100 MHz clock domain.
`default_nettype none
package acg_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int ACG_CLK_HZ    = 100_000_000;
	localparam int ACG_TICK_MS   = 10;                    // One hundredth of a second
	localparam int ACG_TICK_CYC  = ACG_CLK_HZ / 1000 * ACG_TICK_MS;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int ACG_FIFO_DEPTH = 16;
	localparam int ACG_MAX_DROPS  = 8;
	localparam int ACG_MAX_PARAMS = 9;                    // Register plus eight values
	localparam int ACG_ADDR_W     = 8;
	// ------------------------------------------------------------
	// Register offsets, fields and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] ACG_OFS_CTRL      = 8'h00;
	localparam logic [7:0] ACG_OFS_SIZE_LIM  = 8'h04;
	localparam logic [7:0] ACG_OFS_TIME_LIM  = 8'h08;
	localparam logic [7:0] ACG_OFS_ROUTE_LEN = 8'h0C;
	localparam logic [7:0] ACG_OFS_DROP0     = 8'h10;
	localparam logic [7:0] ACG_OFS_STATUS    = 8'h30;
	localparam int         ACG_CTRL_EN_BIT   = 0;
	localparam logic       ACG_RST_EN        = 1'b1;
	localparam logic [7:0] ACG_RST_SIZE_LIM  = 8'h80;     // 128 characters
	localparam logic [7:0] ACG_RST_TIME_LIM  = 8'h64;     // 100 hundredths
	// ------------------------------------------------------------
	// Characters
	// ------------------------------------------------------------
	localparam logic [7:0] ACG_CH_CR = 8'h0D;
	localparam logic [7:0] ACG_CH_LF = 8'h0A;
	localparam logic [7:0] ACG_CH_SP = 8'h20;
	localparam logic [7:0] ACG_CH_0  = 8'h30;
	localparam logic [7:0] ACG_CH_R  = 8'h52;
	localparam logic [7:0] ACG_CH_W  = 8'h57;
	localparam logic [7:0] ACG_CH_S  = 8'h53;
	localparam logic [7:0] ACG_CH_C  = 8'h43;
	localparam logic [7:0] ACG_CH_B  = 8'h42;
	localparam logic [7:0] ACG_CH_P  = 8'h50;
	localparam logic [7:0] ACG_CH_O  = 8'h4F;
	localparam logic [7:0] ACG_CH_A  = 8'h41;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_READ = 2'b00, OP_WRITE = 2'b01, OP_SETBIT = 2'b10, OP_CLRBIT = 2'b11
	} acg_op_e;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_ARGS = 4'h1, ST_PRINT = 4'h2, ST_PCR = 4'h3,
		ST_PLF = 4'h4, ST_PEND = 4'h5, ST_EXEC = 4'h6, ST_REQ = 4'h7,
		ST_RSP = 4'h8, ST_SP = 4'h9, ST_DEC = 4'hA, ST_CR = 4'hB
	} acg_state_e;
endpackage
`default_nettype wire

//--- acg_fifo.sv
// Parameterised FIFO with valid/ready on both sides.
// Assumes one clock; in_ready comes from a flip-flop.
`timescale 1ns/10ps
`default_nettype none
module acg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             in_ready,
	output var  logic             out_valid,
	output var  logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [CW-1:0]               cnt;
		logic                        rdy;
	} acg_fifo_s;
	acg_fifo_s r, n;
	logic push, pop;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		n = r;
		push = in_valid && r.rdy;
		pop  = out_ready && (r.cnt != '0);
		if (push)
		begin
			n.mem[r.wp] = in_data;
			n.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : PW'(r.wp + 1'b1);
		end
		if (pop)
			n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : PW'(r.rp + 1'b1);
		n.cnt = CW'(r.cnt + CW'(push) - CW'(pop));
		n.rdy = (n.cnt != FULL);                      // Honest full: stalls the writer
	end

	// Registered state
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			r <= '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
		else
			r <= n;
	end

	assign in_ready  = r.rdy;
	assign out_valid = (r.cnt != '0);
	assign out_data  = r.mem[r.rp];
endmodule // acg_fifo
`default_nettype wire

//--- acg_gateway_chk.sv
// Port-level assertions for the ASCII command gateway.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module acg_gateway_chk
	import acg_pkg::*;
(
	input wire logic             clk,
	input wire logic             resetn,
	input wire logic             rx_valid,
	input wire logic             rx_ready,
	input wire logic             tx_valid,
	input wire logic [7:0]       tx_data,
	input wire logic             tx_ready,
	input wire logic             net_req_valid,
	input wire acg_pkg::acg_op_e net_req_op,
	input wire logic [15:0]      net_req_addr,
	input wire logic [15:0]      net_req_mask,
	input wire logic             net_local,
	input wire logic             net_req_ready,
	input wire logic             prt_valid,
	input wire logic [7:0]       prt_data,
	input wire logic             prt_last,
	input wire logic             prt_empty,
	input wire logic             prt_ready,
	input wire logic [acg_pkg::ACG_ADDR_W-1:0] reg_addr,
	input wire logic             reg_rd,
	input wire logic [31:0]      reg_rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Stalled outputs must not slip or change
	chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte dropped while stalled");
	chk_net_hold: assert property (net_req_valid && !net_req_ready |=>
		net_req_valid && $stable({net_req_op, net_req_addr, net_req_mask}))
		else $error("network request changed while stalled");
	chk_prt_hold: assert property (prt_valid && !prt_ready |=> prt_valid && $stable(prt_data))
		else $error("print byte changed while stalled");
	chk_prt_last: assert property (prt_valid && prt_last |-> prt_empty && prt_data == 8'h00)
		else $error("final print beat not empty");
	chk_bit_mask: assert property (net_req_valid && net_req_op[1] |-> $onehot0(net_req_mask))
		else $error("bit command touches more than one bit");
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	chk_route_len: assert property (reg_rd && reg_addr == ACG_OFS_ROUTE_LEN |=>
		reg_rdata <= 32'd8 && net_local == (reg_rdata == 32'h0))
		else $error("route length and local target disagree");
	// The FIFO can only fill by taking a byte
	chk_fill_cause: assert property ($fell(rx_ready) |-> $past(rx_valid))
		else $error("receive ready fell without a byte");
	cover property (net_req_valid && net_req_ready && net_req_op == OP_WRITE);
	cover property (prt_valid && prt_ready && prt_last);
	cover property (!rx_ready);
endmodule // acg_gateway_chk
bind acg_gateway acg_gateway_chk u_chk (.clk(clk), .resetn(resetn), .rx_valid(rx_valid),
	.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.net_req_valid(net_req_valid), .net_req_op(net_req_op), .net_req_addr(net_req_addr),
	.net_req_mask(net_req_mask), .net_local(net_local), .net_req_ready(net_req_ready),
	.prt_valid(prt_valid), .prt_data(prt_data), .prt_last(prt_last), .prt_empty(prt_empty),
	.prt_ready(prt_ready), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

//--- acg_term_model.sv
// Terminal model: types command text into the gateway, takes replies.
// Assumes send() is called only after reset has been released.
`timescale 1ns/10ps
`default_nettype none
module acg_term_model (
	input  wire logic       clk,
	input  wire logic       rx_ready,
	output var  logic       rx_valid = 1'b0,
	output var  logic [7:0] rx_data = 8'h00,
	output var  logic       tx_ready = 1'b0
);
	int seed  = 32'h40AC0B36;
	int fails = 0;
	// Replies taken with random stalls, as a slow terminal would
	always @(posedge clk)
		tx_ready <= ($random(seed) % 4) != 0;
	// Bytes held until taken; text ends with CR or a pause
	task automatic send(input string s);
		int k;
		foreach (s[i])
		begin
			rx_valid <= 1'b1;
			rx_data <= s[i];
			k = 0;
			do
			begin
				@(posedge clk);
				k++;
			end
			while (!rx_ready && k < 500);
			if (k == 500)
				fails++;
		end
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;                 // Released line shows no stale byte
	endtask
endmodule // acg_term_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the ASCII command gateway.
// Assumes acg_term_model on the terminal side; the bench plays the network.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import acg_pkg::*;
	logic        clk = 1'b0, resetn = 1'b0, rd_q = 1'b0;
	logic        rx_valid, rx_ready, tx_valid, tx_ready, net_req_valid, net_local;
	logic        prt_valid, prt_last, prt_empty, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        net_req_ready = 1'b0, net_rsp_valid = 1'b0, prt_ready = 1'b0;
	logic [7:0]  rx_data, tx_data, prt_data, reg_addr = 8'h00;
	logic [15:0] net_req_addr, net_req_data, net_req_mask, q_addr, net_rsp_data = 16'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	acg_op_e     net_req_op;
	int          seed = 32'h40AC0B36, dly = 0, err_count = 0, n_compared = 0;
	logic [7:0]  exp_tx[$];
	logic [9:0]  exp_prt[$];
	logic [49:0] exp_net[$];
	logic [31:0] exp_rd[$];
	logic [7:0]  ofs[7] = '{ACG_OFS_CTRL, ACG_OFS_SIZE_LIM, ACG_OFS_TIME_LIM,
		ACG_OFS_ROUTE_LEN, ACG_OFS_DROP0, ACG_OFS_STATUS, 8'h40};
	logic [31:0] rst[7] = '{32'h1, 32'h80, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0};
	// Clock
	initial
	begin
		forever #5 clk = ~clk;
	end
	acg_gateway #(.TICK_CYC(10), .DEPTH(ACG_FIFO_DEPTH)) u_dut (.clk(clk), .resetn(resetn),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .net_req_valid(net_req_valid),
		.net_req_op(net_req_op), .net_req_addr(net_req_addr), .net_req_data(net_req_data),
		.net_req_mask(net_req_mask), .net_local(net_local), .net_req_ready(net_req_ready),
		.net_rsp_valid(net_rsp_valid), .net_rsp_data(net_rsp_data), .net_rsp_err(1'b0),
		.prt_valid(prt_valid), .prt_data(prt_data), .prt_last(prt_last),
		.prt_empty(prt_empty), .prt_ready(prt_ready), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	acg_term_model u_term (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .tx_ready(tx_ready));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] rv(input logic [15:0] a);
		return a * 16'd977 + 16'd5;            // Register contents the network reports
	endfunction
	task automatic put(input string s);
		foreach (s[i]) exp_tx.push_back(s[i]);
	endtask
	// Print beats, then the empty closing beat
	task automatic pp(input string s);
		foreach (s[i]) exp_prt.push_back({2'b00, s[i]});
		exp_prt.push_back(10'h300);
	endtask
	task automatic en(input acg_op_e op, input logic [15:0] a, input logic [31:0] dm);
		exp_net.push_back({op, a, dm});
	endtask
	task automatic put_rd(input logic [15:0] a, input string sep);
		en(OP_READ, a, 32'h0);
		put({$sformatf("%0d", rv(a)), sep});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic final_report();
		err_count += u_term.fails;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Types a command, then waits a bounded time for every reply, request and print note to be met
	task automatic cmd(input string s, input string name);
		int k;
		u_term.send(s);
		k = 0;
		while (exp_tx.size() + exp_net.size() + exp_prt.size() != 0 && k < 3000)
		begin
			@(posedge clk);
			k++;
		end
		if (k == 3000)
		begin
			err_count++;
			final_report();
		end
		repeat (4) @(posedge clk);
		$display("test %s done", name);
	endtask
	// Network side: random stalls, reads answered after a random delay
	always @(posedge clk)
	begin
		net_req_ready <= ($random(seed) % 3) != 0;
		prt_ready <= ($random(seed) % 3) != 0;
		net_rsp_valid <= dly == 1;
		net_rsp_data <= rv(q_addr);
		dly <= (dly > 0) ? dly - 1 : 0;
		if (net_req_valid && net_req_ready)
		begin
			chk({net_req_op, net_req_addr, net_req_op == OP_WRITE ? net_req_data : 16'h0,
				net_req_op[1] ? net_req_mask : 16'h0}, exp_net.pop_front());
			q_addr <= net_req_addr;
			dly <= (net_req_op == OP_READ) ? 2 + {$random(seed)} % 4 : 0;
		end
	end
	// Output watchers: each accepted result meets the oldest note
	always @(posedge clk)
	begin
		rd_q <= reg_rd;
		if (rd_q)
			chk(reg_rdata, exp_rd.pop_front());
		if (tx_valid && tx_ready)
			chk(tx_data, exp_tx.pop_front());
		if (prt_valid && prt_ready)
			chk({prt_empty, prt_last, prt_data}, exp_prt.pop_front());
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		foreach (ofs[i]) rd(ofs[i], rst[i]);
		chk(net_local, 1'b1);
		put_rd(16'd1, " ");
		put_rd(16'd2, "\015");
		cmd("Ralph 1,2\015", "read");
		en(OP_WRITE, 16'd100, 32'h0002_0000);
		en(OP_WRITE, 16'd101, 32'h0003_0000);
		put("\015\015\015");
		en(OP_SETBIT, 16'd12, 32'h0000_0001);
		en(OP_CLRBIT, 16'd12, 32'h0000_8000);
		cmd("wRITE 100=2,3\015s12.1\015Clear 12,16\015", "write set clear");
		en(OP_READ, 16'd7, 32'h0);
		put({$sformatf("%0d", (rv(16'd7) >> 2) & 16'h1), "\015"});
		cmd("Bit 7-3\015", "bit");
		pp("Hi\015\015\n");
		cmd("PHi\015", "print");
		wr(ACG_OFS_TIME_LIM, 32'h2);
		wr(ACG_OFS_SIZE_LIM, 32'h4);
		pp("+");
		cmd("o+", "omit");
		put_rd(16'd9, "\015");
		cmd("r9,1", "size limit");
		wr(ACG_OFS_SIZE_LIM, 32'h80);
		wr(ACG_OFS_TIME_LIM, 32'h64);
		put("\015");
		cmd("A8,10\015", "address"); // Route starts at the gateway's drop
		rd(ACG_OFS_ROUTE_LEN, 32'h2);
		rd(ACG_OFS_DROP0 + 8'h4, 32'd10);
		chk(net_local, 1'b0);
		wr(ACG_OFS_ROUTE_LEN, 32'h0);
		rd(ACG_OFS_ROUTE_LEN, 32'h0);
		wr(ACG_OFS_CTRL, 32'h0);
		repeat (5) put_rd(16'd3, "\015");
		u_term.send("r3\015r3\015r3\015r3\015r3\015 ");
		repeat (2) @(posedge clk);
		chk(rx_ready, 1'b0);
		wr(ACG_OFS_CTRL, 32'h1);
		cmd("", "fifo full");
		chk(net_local, 1'b1);
		final_report();
	end
endmodule // testbench
`default_nettype wire
